// ==== rtl/sdram_defs.svh ====
// constants for the sdram pin and command interface
`ifndef SDRAM_DEFS_SVH
`define SDRAM_DEFS_SVH

// address bit that selects auto precharge or all-bank precharge
`define AP_BIT          10

// mode word field positions
`define MODE_BL_LSB     0
`define MODE_BL_MSB     2
`define MODE_CL_LSB     4
`define MODE_CL_MSB     6

// burst length codes
`define BL_CODE_1       3'h0
`define BL_CODE_2       3'h1
`define BL_CODE_4       3'h2
`define BL_CODE_8       3'h3
`define BL_CODE_FULL    3'h7

// column wrap masks per burst length
`define BL_MASK_2       3'h1
`define BL_MASK_4       3'h3
`define BL_MASK_8       3'h7

// read latency code that adds a pipeline stage
`define CL_THREE        3'h3

// reset values and the single-bank bit
`define MODE_RESET      12'h020
`define BANKS_CLOSED    4'h0
`define MASK_ALL_ON     2'h3
`define ONE_BANK        4'h1

`endif

// ==== rtl/sdram_pin_command_interface.sv ====
// command, address and data pin logic of a four-bank synchronous dram
`timescale 1ns/10ps
`include "sdram_defs.svh"
module sdram_pin_command_interface
   import sdram_pkg::*;
#(
   parameter int ROW_BITS   = 12,
   parameter int COL_BITS   = 8,
   parameter int WBUF_DEPTH = 16
)(
   input  logic        clk,
   input  logic        nrst,
   input  logic        cke,
   input  logic        cs_n,
   input  logic        ras_n,
   input  logic        cas_n,
   input  logic        we_n,
   input  logic [11:0] addr,
   input  logic        bank_sel_bit0,
   input  logic        bank_sel_bit1,
   input  logic        low_byte_mask,
   input  logic        high_byte_mask,
   input  logic [15:0] data_lines_in,
   output logic [15:0] data_lines_out,
   output logic [1:0]  data_lines_oe,
   output logic [3:0]  bank_open,
   output logic [11:0] mode_word,
   output logic [1:0]  lp_state,
   output logic        write_buf_ready
);
   localparam int AW = 2 + ROW_BITS + COL_BITS;
   localparam int FW = AW + 16 + 2;

   ////////////////////////////////////////////////////////////////////////////
   // command decode

   cmd_t                cmd;
   logic [1:0]          bank;
   logic                cmd_ok;
   logic                cmd_cut;
   logic [ROW_BITS-1:0] row_in;
   logic [COL_BITS-1:0] col_in;
   logic [1:0]          mask_in;

   // apart from self refresh entry, only a gated-in edge with chip select low carries a command
   assign cmd     = cmd_t'({ras_n, cas_n, we_n});
   assign cmd_ok  = cke && !cs_n;
   assign bank    = {bank_sel_bit1, bank_sel_bit0};
   assign row_in  = addr[ROW_BITS-1:0];
   assign col_in  = addr[COL_BITS-1:0];
   assign mask_in = {high_byte_mask, low_byte_mask};
   assign cmd_cut = cmd_ok && (cmd == CMD_RD || cmd == CMD_WR ||
                               cmd == CMD_STOP || cmd == CMD_PRE);

   ////////////////////////////////////////////////////////////////////////////
   // mode word

   logic [11:0]         mode_r;
   logic [COL_BITS-1:0] bl_msk;
   logic                cl3;

   // column wrap mask for the programmed burst length
   function automatic logic [COL_BITS-1:0] burst_mask(input logic [2:0] code);
      logic [COL_BITS-1:0] m;
      m = '0;
      case (code)
         `BL_CODE_1:    m = '0;
         `BL_CODE_2:    m = COL_BITS'(`BL_MASK_2);
         `BL_CODE_4:    m = COL_BITS'(`BL_MASK_4);
         `BL_CODE_8:    m = COL_BITS'(`BL_MASK_8);
         `BL_CODE_FULL: m = '1;
         default:       m = '0;
      endcase
      return m;
   endfunction : burst_mask

   assign bl_msk = burst_mask(mode_r[`MODE_BL_MSB:`MODE_BL_LSB]);
   assign cl3    = (mode_r[`MODE_CL_MSB:`MODE_CL_LSB] == `CL_THREE);

   // mode-load takes the whole address word
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mode_r <= `MODE_RESET;
      end
      else if (cmd_ok && cmd == CMD_MODE)
      begin
         mode_r <= addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // burst engine

   logic                rd_act_r;
   logic                wr_act_r;
   logic [1:0]          bst_bank_r;
   logic [ROW_BITS-1:0] bst_row_r;
   logic [COL_BITS-1:0] bst_col_r;
   logic [COL_BITS-1:0] bst_left_r;
   logic                bst_ap_r;
   logic [COL_BITS-1:0] col_step;
   logic                bst_on;
   logic                bst_last;
   logic                ap_close;
   logic [3:0]          bank_open_r;
   logic [ROW_BITS-1:0] row_r [0:3];

   // next column wraps inside the burst-length boundary
   assign col_step = (bst_col_r & ~bl_msk) | ((bst_col_r + 1'b1) & bl_msk);
   assign bst_on   = rd_act_r || wr_act_r;
   assign bst_last = cke && bst_on && (bst_left_r == '0) && !cmd_cut;
   assign ap_close = bst_last && bst_ap_r;

   // start, step, stop and end of a read or write burst
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rd_act_r   <= 1'b0;
         wr_act_r   <= 1'b0;
         bst_bank_r <= '0;
         bst_row_r  <= '0;
         bst_col_r  <= '0;
         bst_left_r <= '0;
         bst_ap_r   <= 1'b0;
      end
      else if (cke)
      begin
         if (cmd_ok && (cmd == CMD_RD || cmd == CMD_WR) && bank_open_r[bank])
         begin
            rd_act_r   <= (cmd == CMD_RD);
            wr_act_r   <= (cmd == CMD_WR);
            bst_bank_r <= bank;
            bst_row_r  <= row_r[bank];
            bst_col_r  <= col_in;
            bst_left_r <= bl_msk;
            bst_ap_r   <= addr[`AP_BIT];
         end
         else if (cmd_cut || bst_last)
         begin
            rd_act_r <= 1'b0;
            wr_act_r <= 1'b0;
            bst_ap_r <= 1'b0;
         end
         else if (bst_on)
         begin
            bst_col_r  <= col_step;
            bst_left_r <= bst_left_r - 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bank state

   // open rows on activate, close on precharge or auto precharge
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bank_open_r <= `BANKS_CLOSED;
         for (int b = 0; b < 4; b++)
         begin
            row_r[b] <= '0;
         end
      end
      else
      begin
         if (ap_close)
         begin
            bank_open_r[bst_bank_r] <= 1'b0;
         end
         if (cmd_ok && cmd == CMD_ACT)
         begin
            bank_open_r[bank] <= 1'b1;
            row_r[bank]       <= row_in;
         end
         else if (cmd_ok && cmd == CMD_PRE)
         begin
            if (addr[`AP_BIT])
            begin
               bank_open_r <= `BANKS_CLOSED;
            end
            else
            begin
               bank_open_r[bank] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // low-power state

   lp_state_t lp_state_r;

   // state chosen at the edge where the gate falls
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         lp_state_r <= LP_NORMAL;
      end
      else if (cke)
      begin
         lp_state_r <= LP_NORMAL;
      end
      else if (lp_state_r == LP_NORMAL)
      begin
         if (!cs_n && cmd == CMD_REF)
         begin
            lp_state_r <= LP_SELF_REF;
         end
         else if (bst_on)
         begin
            lp_state_r <= LP_SUSPEND;
         end
         else
         begin
            lp_state_r <= LP_POWER_DOWN;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write path through the buffer

   logic          push_v;
   logic          push_first;
   logic [FW-1:0] push_word;
   logic          wb_in_ready;
   logic          wb_out_valid;
   logic          wb_out_ready;
   logic [FW-1:0] wb_out_word;
   logic          write_buf_ready_r;

   // beat 0 comes with the command, later beats from the engine
   assign push_first = cmd_ok && cmd == CMD_WR && bank_open_r[bank];
   assign push_v     = (push_first || (cke && wr_act_r && bst_left_r != '0 && !cmd_cut)) &&
                       (mask_in != `MASK_ALL_ON);
   assign push_word  = push_first ?
                       {bank, row_r[bank], col_in, mask_in, data_lines_in} :
                       {bst_bank_r, bst_row_r, col_step, mask_in, data_lines_in};
   // a read fetch owns the array port, so draining stalls
   assign wb_out_ready = !rd_act_r;

   sync_fifo #(
      .WIDTH (FW),
      .DEPTH (WBUF_DEPTH)
   ) i_sync_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (push_v),
      .in_ready  (wb_in_ready),
      .in_data   (push_word),
      .out_valid (wb_out_valid),
      .out_ready (wb_out_ready),
      .out_data  (wb_out_word)
   );

   // buffer room seen by the controller
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         write_buf_ready_r <= 1'b1;
      end
      else
      begin
         write_buf_ready_r <= wb_in_ready;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // storage array

   logic [15:0]   mem [0:(1<<AW)-1];
   logic [AW-1:0] drain_addr;
   logic [1:0]    drain_mask;
   logic [15:0]   drain_data;
   logic [AW-1:0] rd_addr;

   assign drain_addr = wb_out_word[FW-1:18];
   assign drain_mask = wb_out_word[17:16];
   assign drain_data = wb_out_word[15:0];
   assign rd_addr    = {bst_bank_r, bst_row_r, bst_col_r};

   // byte-masked write of drained beats
   always_ff @(posedge clk)
   begin
      if (wb_out_valid && wb_out_ready)
      begin
         for (int b = 0; b < 2; b++)
         begin
            if (!drain_mask[b])
            begin
               mem[drain_addr][b*8 +: 8] <= drain_data[b*8 +: 8];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data pipeline and output enables

   logic        rd_dly_v_r;
   logic [15:0] rd_dly_d_r;
   logic [1:0]  mask_d1_r;
   logic [15:0] data_out_r;
   logic [1:0]  data_oe_r;
   logic        out_v_nxt;

   assign out_v_nxt = cl3 ? rd_dly_v_r : rd_act_r;

   // latency stage, mask delay and output flops, frozen while gated off
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rd_dly_v_r <= 1'b0;
         rd_dly_d_r <= '0;
         mask_d1_r  <= `MASK_ALL_ON;
         data_out_r <= '0;
         data_oe_r  <= '0;
      end
      else if (cke)
      begin
         rd_dly_v_r <= rd_act_r;
         rd_dly_d_r <= mem[rd_addr];
         mask_d1_r  <= mask_in;
         data_out_r <= cl3 ? rd_dly_d_r : mem[rd_addr];
         for (int b = 0; b < 2; b++)
         begin
            data_oe_r[b] <= out_v_nxt && !mask_d1_r[b];
         end
      end
   end

   assign data_lines_out  = data_out_r;
   assign data_lines_oe   = data_oe_r;
   assign bank_open       = bank_open_r;
   assign mode_word       = mode_r;
   assign lp_state        = lp_state_r;
   assign write_buf_ready = write_buf_ready_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   act_row_latch_a : assert property (
      (cmd_ok && cmd == CMD_ACT) |=> bank_open_r[$past(bank)] && row_r[$past(bank)] == $past(row_in))
      else $error("activate did not open the row");

   rd_col_take_a : assert property (
      (cmd_ok && cmd == CMD_RD && bank_open_r[bank]) |=> rd_act_r && bst_col_r == $past(col_in))
      else $error("read start column not taken");

   auto_pre_a : assert property (
      (ap_close && !(cmd_ok && cmd == CMD_ACT)) |=> !bank_open_r[$past(bst_bank_r)])
      else $error("auto precharge left bank open");

   pre_all_a : assert property (
      (cmd_ok && cmd == CMD_PRE && addr[`AP_BIT]) |=> bank_open_r == `BANKS_CLOSED)
      else $error("precharge all left a bank open");

   pre_one_a : assert property (
      (cmd_ok && cmd == CMD_PRE && !addr[`AP_BIT] && !ap_close) |=>
         !bank_open_r[$past(bank)] &&
         ((bank_open_r | (`ONE_BANK << $past(bank))) == ($past(bank_open_r) | (`ONE_BANK << $past(bank)))))
      else $error("single precharge touched another bank");

   mode_take_a : assert property (
      (cmd_ok && cmd == CMD_MODE) |=> mode_r == $past(addr))
      else $error("mode word not loaded");

   cs_hold_a : assert property (
      (cke && cs_n && !ap_close) |=> $stable(bank_open_r) && $stable(mode_r))
      else $error("deselected cycle changed state");

   gate_freeze_a : assert property (
      (!cke) |=> $stable(bank_open_r) && $stable(data_out_r) && $stable(rd_act_r))
      else $error("gated edge changed state");

   gate_state_a : assert property (
      (!cke) |=> lp_state_r != LP_NORMAL)
      else $error("gate low without low-power state");

   rd_mask_lo_a : assert property (
      (cke && low_byte_mask) ##1 cke |=> !data_oe_r[0])
      else $error("masked low byte was driven");

   rd_mask_hi_a : assert property (
      (cke && high_byte_mask) ##1 cke |=> !data_oe_r[1])
      else $error("masked high byte was driven");

   wr_mask_a : assert property (
      (cke && low_byte_mask && high_byte_mask) |-> !push_v)
      else $error("fully masked beat was buffered");

endmodule : sdram_pin_command_interface

// ==== rtl/sdram_pkg.sv ====
// types shared by the sdram pin and command interface
package sdram_pkg;

   // command code from {row strobe, column strobe, write strobe}
   typedef enum logic [2:0] {
      CMD_MODE = 3'h0,
      CMD_REF  = 3'h1,
      CMD_PRE  = 3'h2,
      CMD_ACT  = 3'h3,
      CMD_WR   = 3'h4,
      CMD_RD   = 3'h5,
      CMD_STOP = 3'h6,
      CMD_NOP  = 3'h7
   } cmd_t;

   // state while the clock gate input is low
   typedef enum logic [1:0] {
      LP_NORMAL     = 2'h0,
      LP_POWER_DOWN = 2'h1,
      LP_SUSPEND    = 2'h2,
      LP_SELF_REF   = 2'h3
   } lp_state_t;

endpackage : sdram_pkg

// ==== rtl/sync_fifo.sv ====
// synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module sync_fifo #(
   parameter int WIDTH = 40,
   parameter int DEPTH = 16
)(
   input  logic             clk,
   input  logic             nrst,
   input  logic             in_valid,
   output logic             in_ready,
   input  logic [WIDTH-1:0] in_data,
   output logic             out_valid,
   input  logic             out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store_r [0:DEPTH-1];
   logic [PW-1:0]    wr_ptr_r;
   logic [PW-1:0]    rd_ptr_r;
   logic [PW:0]      count_r;
   logic             push;
   logic             pop;

   // honest full and empty from the fill count
   assign in_ready  = (count_r != (PW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = store_r[rd_ptr_r];

   // storage array
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         store_r[wr_ptr_r] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         case ({push, pop})
            2'h2:    count_r <= count_r + 1'b1;
            2'h1:    count_r <= count_r - 1'b1;
            default: count_r <= count_r;
         endcase
      end
   end

endmodule : sync_fifo

// ==== tb/ctrl_model.sv ====
// memory controller model that drives command, address, mask and write data pins
`timescale 1ns/10ps
module ctrl_model
   import sdram_pkg::*;
(
   input  wire logic clk,
   output logic      cke,
   output logic      cs_n,
   output logic      ras_n,
   output logic      cas_n,
   output logic      we_n,
   output logic [11:0] addr,
   output logic      bank_sel_bit0,
   output logic      bank_sel_bit1,
   output logic      low_byte_mask,
   output logic      high_byte_mask,
   output logic [15:0] data_lines_in
);
   // pins at time zero: deselected, nop, clock enabled
   initial
   begin
      cke = 1'b1;
      cs_n = 1'b1;
      {ras_n, cas_n, we_n} = 3'h7;
      addr = 12'hA5A;
      {bank_sel_bit1, bank_sel_bit0} = 2'h0;
      {high_byte_mask, low_byte_mask} = 2'h0;
      data_lines_in = 16'h5AA5;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one pin cycle, changed just after the rising edge and held the whole cycle
   task automatic drive(input logic sel, input cmd_t code, input logic [11:0] a, input logic [1:0] ba,
                        input logic [1:0] m, input logic [15:0] d, input logic ck);
      @(posedge clk);
      #1;
      cke = ck;
      cs_n = ~sel;
      {ras_n, cas_n, we_n} = code;
      addr = a;
      {bank_sel_bit1, bank_sel_bit0} = ba;
      {high_byte_mask, low_byte_mask} = m;
      data_lines_in = d;
   endtask : drive

   // deselected cycle; released address and data lines flip every cycle
   task automatic idle(input logic [1:0] m, input logic ck);
      drive(1'b0, CMD_NOP, ~addr, {bank_sel_bit1, bank_sel_bit0}, m, ~data_lines_in, ck);
   endtask : idle
endmodule : ctrl_model

// ==== tb/sdram_pin_command_interface_bench.sv ====
// self-checking bench for the sdram pin and command interface
`timescale 1ns/10ps
module sdram_pin_command_interface_bench
   import sdram_pkg::*;
();
   logic        clk;
   logic        nrst;
   logic        cke, cs_n, ras_n, cas_n, we_n;
   logic [11:0] addr;
   logic        bank_sel_bit0, bank_sel_bit1;
   logic        low_byte_mask, high_byte_mask;
   logic [15:0] data_lines_in;
   logic [15:0] data_lines_out;
   logic [1:0]  data_lines_oe;
   logic [3:0]  bank_open;
   logic [11:0] mode_word;
   logic [1:0]  lp_state;
   logic        write_buf_ready;
   logic [15:0] keep;
   int          failures;
   int          tests_run;

   // design and controller model
   sdram_pin_command_interface i_sdram_pin_command_interface (
      .clk(clk), .nrst(nrst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .addr(addr), .bank_sel_bit0(bank_sel_bit0), .bank_sel_bit1(bank_sel_bit1),
      .low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask), .data_lines_in(data_lines_in),
      .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .bank_open(bank_open),
      .mode_word(mode_word), .lp_state(lp_state), .write_buf_ready(write_buf_ready));
   ctrl_model i_ctrl_model (
      .clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
      .bank_sel_bit0(bank_sel_bit0), .bank_sel_bit1(bank_sel_bit1), .low_byte_mask(low_byte_mask),
      .high_byte_mask(high_byte_mask), .data_lines_in(data_lines_in));

   // 25 mhz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare and verdict
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask : chk

   task automatic give_verdict();
      if (failures == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////////
   // access tasks in the pin protocol
   task automatic cmd(input cmd_t c, input logic [11:0] a, input logic [1:0] ba, input logic [1:0] m = 2'h0,
                      input logic [15:0] d = 16'h0000, input logic ck = 1'b1);
      i_ctrl_model.drive(1'b1, c, a, ba, m, d, ck);
   endtask : cmd

   task automatic idle(input int n = 1, input logic [1:0] m = 2'h0);
      repeat (n) i_ctrl_model.idle(m, 1'b1);
   endtask : idle

   // two-beat write, second beat carried by a selected nop
   task automatic wr(input logic [1:0] ba, input logic [11:0] col, input logic [1:0] m0, input logic [15:0] d0,
                     input logic [1:0] m1, input logic [15:0] d1);
      cmd(CMD_WR, col, ba, m0, d0);
      cmd(CMD_NOP, ~col, ba, m1, d1);
      idle(4);
   endtask : wr

   // one read beat against the mask sampled two clocks earlier
   task automatic beat(input logic [1:0] m, input logic [15:0] e);
      keep = {{8{~m[1]}}, {8{~m[0]}}};
      chk("read oe", {14'h0000, ~m}, {14'h0000, data_lines_oe});
      chk("read data", e & keep, data_lines_out & keep);
   endtask : beat

   // two-beat read at latency lat, masks m0 and m1 two clocks before each beat is seen
   task automatic rd(input logic [1:0] ba, input logic [11:0] col, input logic [1:0] m0, input logic [1:0] m1,
                     input logic [15:0] e0, input logic [15:0] e1, input int lat = 2);
      cmd(CMD_RD, col, ba, (lat == 3) ? 2'h0 : m0);
      if (lat == 3)
         idle(1, m0);
      idle(1, m1);
      idle(1);
      beat(m0, e0);
      idle(1);
      beat(m1, e1);
      idle(1);
      chk("oe after burst", 16'h0000, {14'h0000, data_lines_oe});
   endtask : rd

   ////////////////////////////////////////////////////////////////////////////
   // test sequence
   initial
   begin
      failures = 0;
      tests_run = 0;
      keep = 16'h0000;
      nrst = 1'b0;
      repeat (2) @(posedge clk);
      #1 nrst = 1'b1;
      chk("bank_open reset", 16'h0000, 16'(bank_open));
      chk("mode reset", 16'h0020, 16'(mode_word));
      chk("lp reset", 16'h0000, 16'(lp_state));
      chk("oe reset", 16'h0000, 16'(data_lines_oe));
      chk("ready reset", 16'h0001, 16'(write_buf_ready));
      // mode load ignored while deselected, then taken
      i_ctrl_model.drive(1'b0, CMD_MODE, 12'h8A1, 2'h0, 2'h0, 16'h0000, 1'b1);
      idle(1);
      chk("mode deselected", 16'h0020, 16'(mode_word));
      cmd(CMD_MODE, 12'h8A1, 2'h0);
      idle(1);
      chk("mode word", 16'h08A1, 16'(mode_word));
      // open every bank in turn
      for (int b = 0; b < 4; b++)
      begin
         cmd(CMD_ACT, 12'h005 + 12'(b), 2'(b));
         idle(1);
         chk("bank_open act", 16'((1 << (b + 1)) - 1), 16'(bank_open));
      end
      cmd(CMD_PRE, 12'hBFF, 2'h2);
      idle(1);
      chk("precharge one", 16'h000B, 16'(bank_open));
      // deselected precharge and gated activate leave the banks unchanged; the gated edge enters power down
      i_ctrl_model.drive(1'b0, CMD_PRE, 12'h400, 2'h0, 2'h0, 16'h0000, 1'b1);
      cmd(CMD_ACT, 12'h000, 2'h2, 2'h0, 16'h0000, 1'b0);
      idle(1);
      chk("power down", 16'h0001, 16'(lp_state));
      chk("gated banks", 16'h000B, 16'(bank_open));
      idle(1);
      chk("lp normal", 16'h0000, 16'(lp_state));
      cmd(CMD_PRE, 12'h400, 2'h1);
      idle(1);
      chk("precharge all", 16'h0000, 16'(bank_open));
      // byte-masked writes and wrapped, masked reads
      cmd(CMD_ACT, 12'h005, 2'h1);
      wr(2'h1, 12'h004, 2'h0, 16'h1234, 2'h0, 16'hABCD);
      wr(2'h1, 12'h004, 2'h1, 16'hFFFF, 2'h2, 16'h0000);
      rd(2'h1, 12'hB05, 2'h0, 2'h0, 16'hAB00, 16'hFF34);
      rd(2'h1, 12'h004, 2'h2, 2'h1, 16'hFF34, 16'hAB00);
      // another row of the same bank keeps its own data
      cmd(CMD_PRE, 12'h000, 2'h1);
      cmd(CMD_ACT, 12'h006, 2'h1);
      wr(2'h1, 12'h004, 2'h0, 16'h6666, 2'h0, 16'h7777);
      cmd(CMD_PRE, 12'h400, 2'h0);
      cmd(CMD_ACT, 12'h005, 2'h1);
      rd(2'h1, 12'h004, 2'h0, 2'h0, 16'hFF34, 16'hAB00);
      // read with auto precharge closes the bank after the burst
      rd(2'h1, 12'h404, 2'h0, 2'h0, 16'hFF34, 16'hAB00);
      idle(1);
      chk("auto precharge", 16'h0000, 16'(bank_open));
      // self refresh and clock suspend entry
      cmd(CMD_REF, 12'h000, 2'h0, 2'h0, 16'h0000, 1'b0);
      idle(1);
      chk("self refresh", 16'h0003, 16'(lp_state));
      idle(3);
      cmd(CMD_ACT, 12'h005, 2'h1);
      cmd(CMD_RD, 12'h004, 2'h1);
      cmd(CMD_NOP, 12'h000, 2'h0, 2'h0, 16'h0000, 1'b0);
      idle(1);
      chk("suspend", 16'h0002, 16'(lp_state));
      idle(4);
      chk("resume", 16'h0000, 16'(lp_state));
      // writes packed between reads load the buffer, then it drains
      cmd(CMD_MODE, 12'h023, 2'h0);
      for (int i = 0; i < 24; i++)
      begin
         cmd(CMD_WR, 12'(i), 2'h1, 2'h0, 16'(i));
         cmd(CMD_RD, 12'h000, 2'h1);
      end
      idle(40);
      chk("buffer drained", 16'h0001, 16'(write_buf_ready));
      // latency three read over a fully masked write beat and the buffered writes
      cmd(CMD_MODE, 12'h031, 2'h0);
      idle(1);
      chk("mode latency three", 16'h0031, 16'(mode_word));
      wr(2'h1, 12'h005, 2'h3, 16'hDEAD, 2'h0, 16'h0009);
      rd(2'h1, 12'h005, 2'h0, 2'h2, 16'h0005, 16'h0009, 3);
      give_verdict();
   end

   // watchdog far beyond the few hundred cycles the sequence needs
   initial
   begin
      #400000;
      $display("[FAIL] watchdog expected finish seen timeout");
      failures++;
      give_verdict();
   end
endmodule : sdram_pin_command_interface_bench
